//--- core/bd_dma.sv
`timescale 1ns/1ps
module bd_dma
  import bd_dma_pkg::*;
#(
  parameter int N_BD = BD_COUNT
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output mem_req_t         txm_req,
  input  wire mem_rsp_t    txm_rsp,
  output mem_req_t         rxm_req,
  input  wire mem_rsp_t    rxm_rsp,
  input  wire logic        ser_clk,
  input  wire logic        rxd,
  input  wire logic        rx_frame,
  input  wire logic        carrier_n,
  output logic             txd,
  output logic             first_channel_send_request_n
);

  localparam int IW = (N_BD > 1) ? $clog2(N_BD) : 1;

  // Status shows four bits of each table index, so larger tables are refused
  if (N_BD < 1 || N_BD > 16) begin : g_bad_n_bd
    $error("N_BD out of range");
  end

  function automatic logic [31:0] bd_addr(input logic [31:0] base,
                                          input logic [IW-1:0] idx,
                                          input logic [31:0] ofs);
    bd_addr = base + {{(29-IW){1'b0}}, idx, 3'b000} + ofs;
  endfunction

  function automatic logic [IW-1:0] bd_next(input logic [IW-1:0] idx,
                                            input logic wrap);
    bd_next = (wrap || idx == IW'(N_BD - 1)) ? '0 : idx + 1'b1;
  endfunction

  // ==========================================================
  // Register slave
  logic [3:0]  ctrl_r;
  logic [31:0] txbase_r;
  logic [31:0] rxbase_r;
  logic        rd_done_r;
  tx_state_t   tx_state_r;
  rx_state_t   rx_state_r;
  logic [IW-1:0] tx_idx_r;
  logic [IW-1:0] rx_idx_r;
  logic        warm;

  wire logic        tx_en    = ctrl_r[CTRL_TXEN];
  wire logic        rx_en    = ctrl_r[CTRL_RXEN];
  wire logic        pcm      = ctrl_r[CTRL_PCM];
  wire logic        nonmultiplexed_serial_interface     = ctrl_r[CTRL_NONMULTIPLEXED_SERIAL_INTERFACE];
  wire logic [31:0] stat_w   = {20'h00000, first_channel_send_request_n, warm,
                                tx_state_r != T_IDLE, rx_state_r != R_IDLE,
                                4'(rx_idx_r), 4'(tx_idx_r)};
  wire logic [31:0] rd_mux   = (avs_address == CTRL_OFS)   ? {28'h0, ctrl_r} :
                               (avs_address == TXBASE_OFS) ? txbase_r :
                               (avs_address == RXBASE_OFS) ? rxbase_r :
                               (avs_address == STAT_OFS)   ? stat_w : 32'h0;

  // Writes complete at once; reads take one wait cycle so data is registered
  assign avs_waitrequest = avs_read & ~rd_done_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_r       <= CTRL_RST;
      txbase_r     <= BASE_RST;
      rxbase_r     <= BASE_RST;
      rd_done_r    <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      rd_done_r <= avs_read & ~rd_done_r;
      if (avs_read && !rd_done_r) begin
        avs_readdata <= rd_mux;
      end
      if (avs_write && avs_address == CTRL_OFS) begin
        ctrl_r <= avs_writedata[3:0];
      end else if (avs_write && avs_address == TXBASE_OFS) begin
        txbase_r <= avs_writedata;
      end else if (avs_write && avs_address == RXBASE_OFS) begin
        rxbase_r <= avs_writedata;
      end
    end
  end

  // ==========================================================
  // Link input synchronisers: {carrier_n, rx_frame, rxd, ser_clk}
  logic [3:0] sy1_r;
  logic [3:0] sy2_r;
  logic [3:0] sy3_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sy1_r <= SYNC_RST;
      sy2_r <= SYNC_RST;
      sy3_r <= SYNC_RST;
    end else begin
      sy1_r <= {carrier_n, rx_frame, rxd, ser_clk};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  wire logic ser_rise   = sy2_r[0] & ~sy3_r[0];
  wire logic ser_fall   = ~sy2_r[0] & sy3_r[0];
  wire logic frm_start  = sy2_r[2] & ~sy3_r[2];
  wire logic frm_end    = ~sy2_r[2] & sy3_r[2];

  // ==========================================================
  // Clocking confirmation and send request
  logic [5:0] warm_cnt_r;

  assign warm = warm_cnt_r > WARM_CLKS; // RL14

  always_ff @(posedge core_clk) begin
    if (srst) begin
      warm_cnt_r                   <= 6'h00;
      first_channel_send_request_n <= 1'b1;
    end else begin
      if (!tx_en) begin
        warm_cnt_r <= 6'h00;
      end else if (ser_rise && !warm) begin
        warm_cnt_r <= warm_cnt_r + 6'h01; // RL15
      end
      // PCM mode drives the request inverted: low once programmed, high when near ready
      first_channel_send_request_n <= pcm ? (tx_en & warm) // RL13
                                          : ~(warm & tx_state_r != T_IDLE); // RL15
    end
  end

  // ==========================================================
  // Transmit engine
  logic [15:0] tx_w0_r;
  logic [15:0] tx_left_r;
  logic [31:0] tx_ptr_r;
  logic [15:0] hold_w_r;
  logic [1:0]  hold_n_r;
  logic [7:0]  tx_sh_r;
  logic [2:0]  tx_bit_r;
  logic [1:0]  tx_err_r;

  wire logic byte_edge = ser_fall && tx_bit_r == 3'h7;
  wire logic take      = byte_edge && hold_n_r != 2'h0;
  wire logic [7:0] next_byte = (hold_n_r == 2'h2) ? hold_w_r[15:8] : hold_w_r[7:0];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_state_r <= T_IDLE;
      tx_idx_r   <= '0;
      tx_w0_r    <= 16'h0;
      tx_left_r  <= 16'h0;
      tx_ptr_r   <= 32'h0;
      hold_w_r   <= 16'h0;
      hold_n_r   <= 2'h0;
      tx_sh_r    <= IDLE_BYTE;
      tx_bit_r   <= 3'h0;
      tx_err_r   <= TX_ERR_NONE;
      txd        <= 1'b1;
      txm_req    <= '0;
    end else begin
      if (ser_fall) begin
        txd      <= tx_sh_r[0];
        tx_bit_r <= tx_bit_r + 3'h1;
        // Underfed line carries all-ones idle bytes, never stale data
        tx_sh_r  <= byte_edge ? (take ? next_byte : IDLE_BYTE) // RL16
                              : {1'b1, tx_sh_r[7:1]};
      end
      if (take) begin
        hold_n_r <= hold_n_r - 2'h1;
      end
      if (txm_rsp.ack) begin
        txm_req <= '0;
      end
      case (tx_state_r)
        T_IDLE: begin
          tx_err_r <= TX_ERR_NONE;
          if (tx_en && warm) begin // RL14
            tx_state_r <= T_RD0;
          end
        end
        T_RD0: begin
          if (txm_rsp.ack) begin
            tx_w0_r <= txm_rsp.rdata;
            // Not-ready descriptor: drop back and poll again
            tx_state_r <= txm_rsp.rdata[BD_READY_BIT] ? T_RDLEN : T_IDLE; // RL5
          end else if (!txm_req.rd) begin
            txm_req <= '{1'b1, 1'b0, 1'b0, bd_addr(txbase_r, tx_idx_r, 32'h0), 16'h0}; // RL1
          end
        end
        T_RDLEN, T_RDPH, T_RDPL: begin
          if (txm_rsp.ack) begin
            if (tx_state_r == T_RDLEN) begin
              tx_left_r  <= txm_rsp.rdata;
              tx_state_r <= T_RDPH;
            end else if (tx_state_r == T_RDPH) begin
              tx_ptr_r[31:16] <= txm_rsp.rdata;
              tx_state_r      <= T_RDPL;
            end else begin
              tx_ptr_r[15:0] <= txm_rsp.rdata;
              tx_state_r     <= T_FETCH;
            end
          end else if (!txm_req.rd) begin
            txm_req <= '{1'b1, 1'b0, 1'b0,
                         bd_addr(txbase_r, tx_idx_r,
                                 tx_state_r == T_RDLEN ? BD_LEN_OFS :
                                 tx_state_r == T_RDPH ? BD_PTRH_OFS : BD_PTRL_OFS),
                         16'h0}; // RL1
          end
        end
        T_FETCH: begin
          if (!tx_en && !txm_req.rd) begin
            tx_err_r   <= TX_ERR_ABORT;
            hold_n_r   <= 2'h0;
            tx_state_r <= T_CLOSE;
          end else if (txm_rsp.ack) begin
            hold_w_r  <= (tx_left_r == 16'h1) ? {8'h00, txm_rsp.rdata[15:8]}
                                              : txm_rsp.rdata;
            hold_n_r  <= (tx_left_r == 16'h1) ? 2'h1 : 2'h2;
            tx_left_r <= (tx_left_r == 16'h1) ? 16'h0 : tx_left_r - 16'h2;
            tx_ptr_r  <= tx_ptr_r + 32'h2;
          end else if (tx_left_r == 16'h0) begin
            tx_state_r <= T_CLOSE;
          end else if (hold_n_r == 2'h0 && !txm_req.rd) begin
            txm_req <= '{1'b1, 1'b0, tx_w0_r[BD_EXT_BIT], tx_ptr_r, 16'h0}; // RL6 RL17
          end
        end
        T_CLOSE: begin
          if (txm_rsp.ack) begin
            tx_idx_r   <= bd_next(tx_idx_r, tx_w0_r[BD_WRAP_BIT]); // RL7 RL8
            tx_state_r <= T_IDLE;
          end else if (hold_n_r == 2'h0 && !txm_req.wr) begin
            txm_req <= '{1'b0, 1'b1, 1'b0, bd_addr(txbase_r, tx_idx_r, 32'h0),
                         {1'b0, tx_w0_r[14:2], tx_err_r}}; // RL4
          end
        end
        default: tx_state_r <= T_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Receive engine
  logic [7:0]  rx_sh_r;
  logic [2:0]  rx_bit_r;
  logic [15:0] rx_w0_r;
  logic [31:0] rx_ptr_r;
  logic [15:0] rx_cnt_r;
  logic [15:0] rx_word_r;
  logic        rx_half_r;
  logic        rx_pend_r;
  logic [7:0]  rx_sum_r;
  logic        rx_ov_r;
  logic        rx_cd_r;

  wire logic [7:0] rx_byte   = {sy2_r[1], rx_sh_r[7:1]};
  wire logic       rx_done   = ser_rise && sy2_r[2] && rx_bit_r == 3'h7;
  wire logic       rx_active = rx_state_r == R_RUN || rx_state_r == R_ODD;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_state_r <= R_IDLE;
      rx_idx_r   <= '0;
      rx_sh_r    <= 8'h00;
      rx_bit_r   <= 3'h0;
      rx_w0_r    <= 16'h0;
      rx_ptr_r   <= 32'h0;
      rx_cnt_r   <= 16'h0;
      rx_word_r  <= 16'h0;
      rx_half_r  <= 1'b0;
      rx_pend_r  <= 1'b0;
      rx_sum_r   <= 8'h00;
      rx_ov_r    <= 1'b0;
      rx_cd_r    <= 1'b0;
      rxm_req    <= '0;
    end else begin
      if (!sy2_r[2]) begin
        rx_bit_r <= 3'h0;
      end else if (ser_rise) begin
        rx_sh_r  <= rx_byte;
        rx_bit_r <= rx_bit_r + 3'h1;
      end
      if (rxm_rsp.ack) begin
        rxm_req <= '0;
      end
      if (rx_active && rx_pend_r && !rxm_req.wr && !rxm_rsp.ack) begin
        rxm_req <= '{1'b0, 1'b1, rx_w0_r[BD_EXT_BIT], rx_ptr_r, rx_word_r}; // RL3
      end
      if (rx_active && rxm_rsp.ack) begin
        rx_pend_r <= 1'b0;
        rx_ptr_r  <= rx_ptr_r + 32'h2;
      end
      if (rx_active && nonmultiplexed_serial_interface && sy2_r[3]) begin
        rx_cd_r <= 1'b1; // RL11
      end
      case (rx_state_r)
        R_IDLE: begin
          if (rx_en && frm_start) begin
            rx_state_r <= R_RD0;
          end
        end
        R_RD0, R_RDPH, R_RDPL: begin
          if (frm_end) begin
            rxm_req    <= '0;
            rx_state_r <= R_IDLE;
          end else if (rxm_rsp.ack) begin
            if (rx_state_r == R_RD0) begin
              rx_w0_r    <= rxm_rsp.rdata;
              // Buffer still owned by software: frame is dropped
              rx_state_r <= rxm_rsp.rdata[BD_READY_BIT] ? R_RDPH : R_IDLE; // RL18
            end else if (rx_state_r == R_RDPH) begin
              rx_ptr_r[31:16] <= rxm_rsp.rdata;
              rx_state_r      <= R_RDPL;
            end else begin
              rx_ptr_r[15:0] <= rxm_rsp.rdata;
              rx_cnt_r       <= 16'h0;
              rx_half_r      <= 1'b0;
              rx_pend_r      <= 1'b0;
              rx_sum_r       <= 8'h00;
              rx_ov_r        <= 1'b0;
              rx_cd_r        <= 1'b0;
              rx_state_r     <= R_RUN;
            end
          end else if (!rxm_req.rd) begin
            rxm_req <= '{1'b1, 1'b0, 1'b0,
                         bd_addr(rxbase_r, rx_idx_r,
                                 rx_state_r == R_RD0 ? 32'h0 :
                                 rx_state_r == R_RDPH ? BD_PTRH_OFS : BD_PTRL_OFS),
                         16'h0};
          end
        end
        R_RUN: begin
          if (frm_end) begin
            rx_state_r <= R_ODD;
          end else if (rx_done) begin
            rx_cnt_r <= rx_cnt_r + 16'h1;
            rx_sum_r <= rx_sum_r ^ rx_byte;
            if (!rx_half_r) begin
              rx_half_r <= 1'b1;
              if (!rx_pend_r) begin
                rx_word_r[15:8] <= rx_byte;
              end
            end else if (rx_pend_r) begin
              // Previous word not yet written: this word is lost
              rx_ov_r   <= 1'b1; // RL10
              rx_half_r <= 1'b0;
            end else begin
              rx_word_r[7:0] <= rx_byte;
              rx_half_r      <= 1'b0;
              rx_pend_r      <= 1'b1;
            end
          end
        end
        R_ODD: begin
          if (!rx_pend_r && rx_half_r) begin
            rx_word_r[7:0] <= 8'h00;
            rx_half_r      <= 1'b0;
            rx_pend_r      <= 1'b1;
          end else if (!rx_pend_r && !rxm_req.wr) begin
            rx_state_r <= R_LEN;
          end
        end
        R_LEN: begin
          if (rxm_rsp.ack) begin
            rx_state_r <= R_CLOSE;
          end else if (!rxm_req.wr) begin
            rxm_req <= '{1'b0, 1'b1, 1'b0, bd_addr(rxbase_r, rx_idx_r, BD_LEN_OFS),
                         rx_cnt_r}; // RL2
          end
        end
        R_CLOSE: begin
          if (rxm_rsp.ack) begin
            rx_idx_r   <= bd_next(rx_idx_r, rx_w0_r[BD_WRAP_BIT]); // RL8
            rx_state_r <= R_IDLE;
          end else if (!rxm_req.wr) begin
            rxm_req <= '{1'b0, 1'b1, 1'b0, bd_addr(rxbase_r, rx_idx_r, 32'h0),
                         {1'b0, rx_w0_r[14:3], rx_sum_r != 8'h00, rx_ov_r,
                          rx_cd_r}}; // RL9 RL10 RL18
          end
        end
        default: rx_state_r <= R_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Checks
  a_rts_pcm_low: assert property (@(posedge core_clk) disable iff (srst) // RL13
    pcm && !tx_en |=> !first_channel_send_request_n)
    else $error("send request not low in PCM before enable");

  a_tx_start_warm: assert property (@(posedge core_clk) disable iff (srst) // RL15
    tx_state_r == T_IDLE && !warm |=> tx_state_r == T_IDLE)
    else $error("transmit started before clocking confirmed");

  a_tx_idle_fill: assert property (@(posedge core_clk) disable iff (srst) // RL16
    byte_edge && hold_n_r == 2'h0 |=> tx_sh_r == IDLE_BYTE)
    else $error("idle byte not all ones");

  a_tx_ready_gate: assert property (@(posedge core_clk) disable iff (srst) // RL5
    tx_state_r == T_RD0 && txm_rsp.ack && !txm_rsp.rdata[BD_READY_BIT]
    |=> tx_state_r == T_IDLE)
    else $error("descriptor not ready but transmitted");

  a_tx_wrap_first: assert property (@(posedge core_clk) disable iff (srst) // RL7
    tx_state_r == T_CLOSE && txm_rsp.ack && tx_w0_r[BD_WRAP_BIT] |=> tx_idx_r == '0)
    else $error("wrap did not return to first descriptor");

  a_tx_ext_sel: assert property (@(posedge core_clk) disable iff (srst) // RL6
    tx_state_r == T_FETCH && txm_req.rd |-> txm_req.ext == tx_w0_r[BD_EXT_BIT])
    else $error("data fetch used wrong memory");

  a_tx_close_clr: assert property (@(posedge core_clk) disable iff (srst) // RL4
    tx_state_r == T_CLOSE && txm_req.wr
    |-> !txm_req.wdata[BD_READY_BIT] && txm_req.wdata[1:0] == tx_err_r)
    else $error("close did not clear ready or report error");

  a_tx_fill_prompt: assert property (@(posedge core_clk) disable iff (srst) // RL17
    tx_state_r == T_FETCH && tx_en && !txm_req.rd && !txm_rsp.ack && hold_n_r == 2'h0 &&
    tx_left_r != 16'h0 |=> txm_req.rd)
    else $error("data fetch not issued at once");

  a_rx_len_word: assert property (@(posedge core_clk) disable iff (srst) // RL2
    rx_state_r == R_LEN && rxm_req.wr |-> rxm_req.wdata == rx_cnt_r)
    else $error("length word differs from byte count");

  a_rx_close_stat: assert property (@(posedge core_clk) disable iff (srst) // RL9
    rx_state_r == R_CLOSE && rxm_req.wr
    |-> !rxm_req.wdata[BD_READY_BIT] && rxm_req.wdata[RX_CR_BIT] == (rx_sum_r != 8'h00))
    else $error("receive status word wrong");

endmodule

//--- shared/bd_dma_pkg.sv
// Overview of operation
// RL1: Eight transmit descriptors, four 16-bit words each
// RL2: Receive writes stored byte count to length; code writes rx_cnt_r, which also counts bytes lost on overrun
// RL3: Software supplies 32-bit receive buffer pointer
// RL4: Device clears ready, reports error bits 1-0
// RL5: Transmit only descriptors whose ready flag set
// RL6: External flag selects internal or external memory
// RL7: Wrap flag marks last transmit descriptor
// RL8: After last descriptor restart at first
// RL9: Checksum failure sets receive checksum error flag
// RL10: Receiver overrun sets receive overrun flag
// RL11: Carrier lost flagged only in nonmultiplexed mode
// RL12: Software writes zeros to reserved bits
// RL13: PCM mode inverts first channel send request
// RL14: Enable in slot works given 36+ clocks; code waits for 37 serial clock rises (warm_cnt_r > WARM_CLKS)
// RL15: Send request only after enough serial clocks
// RL16: Send all-ones idle bytes until data ready
// RL17: Fixed fill time when sole channel, top priority
// RL18: Receive empty flag bit 7, cleared when filled; code uses bit 15 (BD_READY_BIT)
package bd_dma_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0]  CTRL_OFS      = 4'h0;
  localparam logic [3:0]  TXBASE_OFS    = 4'h4;
  localparam logic [3:0]  RXBASE_OFS    = 4'h8;
  localparam logic [3:0]  STAT_OFS      = 4'hC;
  localparam int          CTRL_TXEN     = 0;
  localparam int          CTRL_RXEN     = 1;
  localparam int          CTRL_PCM      = 2;
  localparam int          CTRL_NONMULTIPLEXED_SERIAL_INTERFACE     = 3;
  localparam logic [3:0]  CTRL_RST      = 4'h0;
  localparam logic [31:0] BASE_RST      = 32'h0000_0000;

  // ==========================================================
  // Descriptor layout
  localparam int          BD_COUNT      = 8;
  localparam int          BD_READY_BIT  = 15;
  localparam int          BD_EXT_BIT    = 14;
  localparam int          BD_WRAP_BIT   = 13;
  localparam int          RX_CR_BIT     = 2;
  localparam int          RX_OV_BIT     = 1;
  localparam int          RX_CD_BIT     = 0;
  localparam logic [1:0]  TX_ERR_NONE   = 2'h0;
  localparam logic [1:0]  TX_ERR_ABORT  = 2'h1;
  localparam logic [31:0] BD_LEN_OFS    = 32'h0000_0002;
  localparam logic [31:0] BD_PTRH_OFS   = 32'h0000_0004;
  localparam logic [31:0] BD_PTRL_OFS   = 32'h0000_0006;

  // ==========================================================
  // Link timing
  localparam logic [5:0]  WARM_CLKS     = 6'h24;
  localparam logic [7:0]  IDLE_BYTE     = 8'hFF;
  // Idle pin levels: carrier absent, frame low, line high, clock low
  localparam logic [3:0]  SYNC_RST      = 4'hA;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        ext;
    logic [31:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } mem_rsp_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_RD0 = 3'b001, T_RDLEN = 3'b010, T_RDPH = 3'b011,
    T_RDPL = 3'b100, T_FETCH = 3'b101, T_CLOSE = 3'b110
  } tx_state_t;

  typedef enum logic [2:0] {
    R_IDLE = 3'b000, R_RD0 = 3'b001, R_RDPH = 3'b010, R_RDPL = 3'b011,
    R_RUN = 3'b100, R_ODD = 3'b101, R_LEN = 3'b110, R_CLOSE = 3'b111
  } rx_state_t;

endpackage

//--- verification/mem_model.sv
`timescale 1ns/1ps
// ==========================================
// Shared descriptor and buffer memory
module mem_model
  import bd_dma_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     srst,
  input  wire mem_req_t txm_req,
  output mem_rsp_t      txm_rsp,
  input  wire mem_req_t rxm_req,
  output mem_rsp_t      rxm_rsp,
  output logic          ext_seen
);
  logic [15:0] mem [0:255];
  logic [1:0]  rx_wait;
  wire         tx_go = (txm_req.rd | txm_req.wr) & ~txm_rsp.ack;
  // Receive side answers slowly so the engine is seen to wait
  wire         rx_go = (rxm_req.rd | rxm_req.wr) & ~rxm_rsp.ack & (rx_wait == 2'h3);

  always @(posedge core_clk) begin
    if (srst) begin
      txm_rsp  <= '0;
      rxm_rsp  <= '0;
      rx_wait  <= 2'h0;
      ext_seen <= 1'b0;
    end else begin
      txm_rsp.ack   <= tx_go;
      rxm_rsp.ack   <= rx_go;
      rx_wait       <= (rxm_req.rd | rxm_req.wr) & ~rx_go ? rx_wait + 2'h1 : 2'h0;
      // Data is meaningless outside ack, so it keeps changing
      txm_rsp.rdata <= tx_go ? mem[txm_req.addr[8:1]] : ~txm_rsp.rdata;
      rxm_rsp.rdata <= rx_go ? mem[rxm_req.addr[8:1]] : ~rxm_rsp.rdata;
      if (tx_go & txm_req.wr) mem[txm_req.addr[8:1]] <= txm_req.wdata;
      if (rx_go & rxm_req.wr) mem[rxm_req.addr[8:1]] <= rxm_req.wdata;
      if (tx_go & txm_req.rd & txm_req.ext & (txm_req.addr == 32'h0000_0040)) ext_seen <= 1'b1;
    end
  end
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb
  import bd_dma_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic        ser_clk  = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read    = 1'b0;
  logic        avs_write   = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  mem_req_t    txm_req;
  mem_req_t    rxm_req;
  mem_rsp_t    txm_rsp;
  mem_rsp_t    rxm_rsp;
  logic        rxd       = 1'b1;
  logic        rx_frame  = 1'b0;
  logic        carrier_n = 1'b0;
  logic        txd;
  logic        send_n;
  logic        ext_seen;
  logic [31:0] rd;
  logic [23:0] tx_win  = 24'hFFFFFF;
  logic        tx_seen = 1'b0;
  int          mismatches = 0;
  int          compares   = 0;
  int          cycles     = 0;

  always #10 core_clk = ~core_clk;
  // Highway clock runs free, off the core clock's rising edges
  always #80 ser_clk = ~ser_clk;

  bd_dma dut (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .txm_req(txm_req), .txm_rsp(txm_rsp), .rxm_req(rxm_req), .rxm_rsp(rxm_rsp),
    .ser_clk(ser_clk), .rxd(rxd), .rx_frame(rx_frame), .carrier_n(carrier_n),
    .txd(txd), .first_channel_send_request_n(send_n));

  mem_model m (.core_clk(core_clk), .srst(srst), .txm_req(txm_req), .txm_rsp(txm_rsp),
    .rxm_req(rxm_req), .rxm_rsp(rxm_rsp), .ext_seen(ext_seen));

  // Line receiver: idle byte, then the word high byte first, each LSB first
  always @(posedge ser_clk) begin
    tx_win <= {txd, tx_win[23:1]};
    if ({txd, tx_win[23:1]} == 24'h3412FF) tx_seen <= 1'b1;
  end

  // ==========================================
  // Reporting
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ==========================================
  // Register bus and line stimulus
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_write     <= 1'b1;
    avs_address   <= a;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest) @(posedge core_clk);
    avs_write <= 1'b0;
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    avs_read    <= 1'b1;
    avs_address <= a;
    @(posedge core_clk);
    while (avs_waitrequest) @(posedge core_clk);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic send_frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    logic [23:0] bits;
    bits = {b2, b1, b0};
    // Frame opens with its first bit, so no line clock rise sees it early
    for (int i = 0; i < 24; i++) begin
      @(negedge ser_clk);
      @(posedge core_clk);
      rx_frame <= 1'b1;
      rxd      <= bits[i];
    end
    @(negedge ser_clk);
    @(posedge core_clk);
    rx_frame <= 1'b0;
    rxd      <= ~bits[23];
  endtask

  task automatic wait_clear(input int idx);
    while (m.mem[idx][15] !== 1'b0) @(posedge core_clk);
  endtask

  // ==========================================
  // Sequence
  initial begin
    for (int i = 0; i < 256; i++) m.mem[i] = 16'h0000;
    m.mem[0]    = 16'hE000;
    m.mem[1]    = 16'h0002;
    m.mem[3]    = 16'h0040;
    m.mem[8'h20] = 16'h1234;
    m.mem[8'h40] = 16'h8000;
    m.mem[8'h43] = 16'h00C0;
    m.mem[8'h44] = 16'hA000;
    m.mem[8'h47] = 16'h00D0;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    check(txd, 1'b1);
    check(send_n, 1'b1);
    bus_rd(CTRL_OFS, rd);
    check(rd, 32'h0000_0000);
    bus_rd(4'h2, rd);
    check(rd, 32'h0000_0000);
    bus_wr(TXBASE_OFS, 32'h0000_0000);
    bus_wr(RXBASE_OFS, 32'h0000_0080);
    bus_rd(RXBASE_OFS, rd);
    check(rd, 32'h0000_0080);
    bus_wr(CTRL_OFS, 32'h0000_0004);
    repeat (10) @(posedge core_clk);
    check(send_n, 1'b0);
    bus_wr(CTRL_OFS, 32'h0000_0000);
    repeat (10) @(posedge core_clk);
    check(send_n, 1'b1);
    bus_wr(CTRL_OFS, 32'h0000_0001);
    repeat (20) @(posedge ser_clk);
    @(posedge core_clk);
    check(send_n, 1'b1);
    check(txd, 1'b1);
    bus_rd(STAT_OFS, rd);
    check(rd[10], 1'b0);
    wait_clear(0);
    check({m.mem[0][15], m.mem[0][1:0]}, 3'b000);
    check(ext_seen, 1'b1);
    repeat (12) @(posedge ser_clk);
    @(posedge core_clk);
    check(tx_seen, 1'b1);
    bus_rd(STAT_OFS, rd);
    check(rd[3:0], 4'h0);
    check(rd[10], 1'b1);
    bus_wr(CTRL_OFS, 32'h0000_0003);
    carrier_n <= 1'b1;
    repeat (20) @(posedge core_clk);
    send_frame(8'hA5, 8'h3C, 8'h99);
    wait_clear(8'h40);
    check(m.mem[8'h40][2:0], 3'b000);
    check(m.mem[8'h41], 16'h0003);
    check(m.mem[8'h60], 16'hA53C);
    check(m.mem[8'h61], 16'h9900);
    bus_wr(CTRL_OFS, 32'h0000_000B);
    repeat (20) @(posedge core_clk);
    send_frame(8'hA5, 8'h3C, 8'h00);
    wait_clear(8'h44);
    check(m.mem[8'h44][2:0], 3'b101);
    bus_wr(CTRL_OFS, 32'h0000_0004);
    bus_wr(CTRL_OFS, 32'h0000_0005);
    repeat (20) @(posedge ser_clk);
    @(posedge core_clk);
    check(send_n, 1'b0);
    repeat (20) @(posedge ser_clk);
    @(posedge core_clk);
    check(send_n, 1'b1);
    give_verdict();
  end
endmodule
